// File: verilog/hwic_defines.vh
// Constants for the host write, interrupt and carrier-detect control block
// Assumes inclusion by bare name from design files
`ifndef HWIC_DEFINES_VH
`define HWIC_DEFINES_VH
`define HWIC_ADDR_W       8
`define HWIC_DATA_W       8
`define HWIC_NUM_SRC      8
// Register addresses
`define HWIC_ADDR_CTRL    8'h00
`define HWIC_ADDR_MASK    8'h01
`define HWIC_ADDR_STATUS  8'h02
`define HWIC_ADDR_LIVE    8'h03
// Interrupt source bit positions
`define HWIC_SRC_LOP      0
`define HWIC_SRC_LAIS     1
`define HWIC_SRC_LFERF    2
`define HWIC_SRC_LOF      3
`define HWIC_SRC_OOF      4
`define HWIC_SRC_LOS      5
`define HWIC_SRC_B1       6
`define HWIC_SRC_LCD      7
// Reset values
`define HWIC_RST_BYTE     8'h00
`define HWIC_RST_MASK     8'hFF
// Synchroniser idle patterns
`define HWIC_SYNC_HI      3'h7
`define HWIC_SYNC_LO      3'h0
// Reference multiplier for clock recovery fallback
`define HWIC_REF_MULT     4'h8
`endif

// File: verilog/hwic_top.v
// Host register port with write capture, read-clear interrupt and carrier-detect handling
// Assumes async host strobes, one 125 MHz system clock, sync reset from the power-on logic
//
// What this block does
// (RULE1) Capture data on write rise with select low
// (RULE2) Host holds select low through each access
// (RULE3) Interrupt low while any unmasked source active
// (RULE4) Reading status register releases the interrupt
// (RULE5) Sources: pointer, AIS, FERF, frame, OOF, signal, B1, LCD
// (RULE6) Carrier low: recovery tracks line data
// (RULE7) Carrier high: recovery locks to eight times reference
// (RULE8) Carrier high sets loss-of-signal alarm bit
// (RULE9) Reset pin low resets host registers, address latch and interrupt, not synchronisers or recovery select
// (RULE10) Reset pin low holds power-down mode
// (RULE11) Factory test clock held low by system
// (RULE12) Drive data only while read and select low
// (RULE13) Address latch transparent while latch enable high
// (RULE14) Synchronise strobes and carrier before use; the data drive enable also gates on the raw read strobe and select pins
// (RULE15) After reset sources clear, interrupt high
`include "hwic_defines.vh"
`default_nettype none
module hwic_top (
  // Clock and reset
  input  wire                       clock_i,
  input  wire                       sys_rst_i,
  // Host bus pins
  input  wire [`HWIC_ADDR_W-1:0]    addr_i,
  input  wire                       addr_latch_en_i,
  input  wire                       chip_select_n_i,
  input  wire                       write_strobe_n_i,
  input  wire                       read_strobe_n_i,
  input  wire [`HWIC_DATA_W-1:0]    data_i,
  output wire [`HWIC_DATA_W-1:0]    data_o,
  output wire                       data_oe_o,
  // Interrupt pin, open drain
  output wire                       irq_n_o,
  output wire                       irq_n_oe_o,
  // Line-side inputs
  input  wire                       carrier_detect_in_i,
  input  wire                       reset_powerdown_n_i,
  input  wire                       factory_test_clk_i,
  input  wire [`HWIC_NUM_SRC-1:0]   alarm_src_i,
  // Status outputs to the rest of the device
  output reg                        los_alarm_status_o,
  output reg                        cdr_ref_lock_o,
  output reg  [3:0]                 cdr_ref_mult_o,
  output reg                        powerdown_o,
  output reg  [`HWIC_DATA_W-1:0]    ctrl_o
);

  // Three-stage synchronisers for async pins
  reg [2:0] wr_sync;
  reg [2:0] cs_sync;
  reg [2:0] rd_sync;
  reg [2:0] cd_sync;
  reg [2:0] rst_sync;
  reg [2:0] tck_sync;
  reg       wr_n;
  reg       cs_n;
  reg       rd_n;
  reg       cd;
  reg       rstp_n;
  reg       test_on;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_sync  <= `HWIC_SYNC_HI;
      cs_sync  <= `HWIC_SYNC_HI;
      rd_sync  <= `HWIC_SYNC_HI;
      cd_sync  <= `HWIC_SYNC_LO;
      rst_sync <= `HWIC_SYNC_HI;
      tck_sync <= `HWIC_SYNC_LO;
    end else begin
      wr_sync  <= {wr_sync[1:0], write_strobe_n_i};     // [RULE14]
      cs_sync  <= {cs_sync[1:0], chip_select_n_i};      // [RULE14]
      rd_sync  <= {rd_sync[1:0], read_strobe_n_i};
      cd_sync  <= {cd_sync[1:0], carrier_detect_in_i};  // [RULE14]
      rst_sync <= {rst_sync[1:0], reset_powerdown_n_i};
      tck_sync <= {tck_sync[1:0], factory_test_clk_i};
    end
  end

  // Filtered levels: change only once stages two and three agree
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_n    <= 1'b1;
      cs_n    <= 1'b1;
      rd_n    <= 1'b1;
      cd      <= 1'b0;
      rstp_n  <= 1'b1;
      test_on <= 1'b0;
    end else begin
      if (wr_sync[1] == wr_sync[2]) wr_n <= wr_sync[2];
      if (cs_sync[1] == cs_sync[2]) cs_n <= cs_sync[2];
      if (rd_sync[1] == rd_sync[2]) rd_n <= rd_sync[2];
      if (cd_sync[1] == cd_sync[2]) cd <= cd_sync[2];
      if (rst_sync[1] == rst_sync[2]) rstp_n <= rst_sync[2];
      if (tck_sync[1] == tck_sync[2]) test_on <= tck_sync[2];  // [RULE11]
    end
  end

  // Write data pins: same three stages and agree filter as the strobe
  // Keeps the captured byte aligned with the lagging internal strobe,
  // so a host that releases data at its strobe's rising edge still lands
  reg  [`HWIC_DATA_W-1:0] dat_s0;
  reg  [`HWIC_DATA_W-1:0] dat_s1;
  reg  [`HWIC_DATA_W-1:0] dat_s2;
  reg  [`HWIC_DATA_W-1:0] dat_f;
  wire [`HWIC_DATA_W-1:0] dat_agree = ~(dat_s1 ^ dat_s2);
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dat_s0 <= `HWIC_RST_BYTE;
      dat_s1 <= `HWIC_RST_BYTE;
      dat_s2 <= `HWIC_RST_BYTE;
      dat_f  <= `HWIC_RST_BYTE;
    end else begin
      dat_s0 <= data_i;                                       // [RULE14]
      dat_s1 <= dat_s0;
      dat_s2 <= dat_s1;
      dat_f  <= (dat_f & ~dat_agree) | (dat_s2 & dat_agree);  // Per-bit agree
    end
  end

  // Internal reset: system reset or reset pin low
  wire int_rst = sys_rst_i | ~rstp_n;  // [RULE9]

  // Address latch, transparent while enable high
  reg  [`HWIC_ADDR_W-1:0] addr_hold;
  wire [`HWIC_ADDR_W-1:0] addr_eff = addr_latch_en_i ? addr_i : addr_hold;  // [RULE13]
  always @(posedge clock_i) begin
    if (int_rst)
      addr_hold <= `HWIC_RST_BYTE;
    else if (addr_latch_en_i)
      addr_hold <= addr_i;  // [RULE13]
  end

  // Previous strobe levels for edge detection
  reg wr_n_d;
  reg rd_n_d;
  reg [`HWIC_ADDR_W-1:0] wr_addr;
  reg [`HWIC_DATA_W-1:0] wr_data;
  always @(posedge clock_i) begin
    if (int_rst) begin
      wr_n_d  <= 1'b1;
      rd_n_d  <= 1'b1;
      wr_addr <= `HWIC_RST_BYTE;
      wr_data <= `HWIC_RST_BYTE;
    end else begin
      wr_n_d <= wr_n;
      rd_n_d <= rd_n;
      if (!wr_n) begin
        wr_addr <= addr_eff;
        wr_data <= dat_f;  // [RULE1]
      end
    end
  end

  // Write takes effect on the strobe's rising edge with select low
  wire wr_rise  = wr_n & ~wr_n_d & ~cs_n;  // [RULE1] [RULE2]
  wire rd_fall  = ~rd_n & rd_n_d & ~cs_n;
  wire rd_end   = rd_n & ~rd_n_d & ~cs_n;

  // Source set: carrier high forces loss of signal
  wire [`HWIC_NUM_SRC-1:0] live_src;
  assign live_src = alarm_src_i | ({{(`HWIC_NUM_SRC-1){1'b0}}, cd} << `HWIC_SRC_LOS);  // [RULE5] [RULE8]

  // Registers: control, mask, sticky status
  reg [`HWIC_DATA_W-1:0]  mask;
  reg [`HWIC_NUM_SRC-1:0] status;
  reg [`HWIC_DATA_W-1:0]  rd_data;
  reg                     rd_status;
  always @(posedge clock_i) begin
    if (int_rst) begin
      ctrl_o    <= `HWIC_RST_BYTE;
      mask      <= `HWIC_RST_MASK;
      status    <= `HWIC_RST_BYTE;  // [RULE15]
      rd_status <= 1'b0;
    end else begin
      if (wr_rise && wr_addr == `HWIC_ADDR_CTRL)
        ctrl_o <= wr_data;  // [RULE1]
      if (wr_rise && wr_addr == `HWIC_ADDR_MASK)
        mask <= wr_data;  // [RULE1]
      if (rd_fall)
        rd_status <= (addr_eff == `HWIC_ADDR_STATUS);
      // Clear on end of status read; a new event still sets
      if (rd_end && rd_status)
        status <= live_src;  // [RULE4]
      else
        status <= status | live_src;  // [RULE5]
    end
  end

  // Read data captured at start of read
  always @(posedge clock_i) begin
    if (int_rst)
      rd_data <= `HWIC_RST_BYTE;
    else if (rd_fall) begin
      case (addr_eff)
        `HWIC_ADDR_CTRL:   rd_data <= ctrl_o;
        `HWIC_ADDR_MASK:   rd_data <= mask;
        `HWIC_ADDR_STATUS: rd_data <= status;
        `HWIC_ADDR_LIVE:   rd_data <= live_src;
        default:           rd_data <= `HWIC_RST_BYTE;
      endcase
    end
  end

  // Data bus driven only during qualified read
  assign data_o    = rd_data;
  assign data_oe_o = ~read_strobe_n_i & ~chip_select_n_i & ~rd_n & ~cs_n;  // [RULE12]

  // Open-drain interrupt: pull low on unmasked sticky source
  wire irq_act = |(status & ~mask);  // [RULE3]
  assign irq_n_o    = 1'b0;
  assign irq_n_oe_o = irq_act;  // [RULE3] [RULE15]

  // Clock recovery source select and alarm, power-down
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      los_alarm_status_o <= 1'b0;
      cdr_ref_lock_o     <= 1'b0;
      cdr_ref_mult_o     <= `HWIC_REF_MULT;
      powerdown_o        <= 1'b0;
    end else begin
      los_alarm_status_o <= rstp_n & status[`HWIC_SRC_LOS];  // [RULE8]
      cdr_ref_lock_o     <= cd;                              // [RULE6] [RULE7]
      cdr_ref_mult_o     <= `HWIC_REF_MULT;                  // [RULE7]
      powerdown_o        <= ~rstp_n | test_on;               // [RULE10]
    end
  end

endmodule // hwic_top
`default_nettype wire

// File: test/hwic_top_properties.sv
// Checker: port properties of hwic_top
// Assumes one clock domain; bound below
`default_nettype none
module hwic_chk (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       chip_select_n_i,
  input wire logic       read_strobe_n_i,
  input wire logic       carrier_detect_in_i,
  input wire logic       reset_powerdown_n_i,
  input wire logic       data_oe_o,
  input wire logic       irq_n_oe_o,
  input wire logic       los_alarm_status_o,
  input wire logic       cdr_ref_lock_o,
  input wire logic [3:0] cdr_ref_mult_o,
  input wire logic       powerdown_o,
  input wire logic [7:0] ctrl_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Held input conditions, long enough to pass the synchronisers
  sequence cd_hi; (carrier_detect_in_i && reset_powerdown_n_i)[*8]; endsequence
  sequence cd_lo; (!carrier_detect_in_i && reset_powerdown_n_i)[*8]; endsequence
  sequence pd_lo; (!reset_powerdown_n_i)[*8]; endsequence
  sequence cs_off; (chip_select_n_i && reset_powerdown_n_i)[*8]; endsequence
  drive_gate_a: assert property ((read_strobe_n_i || chip_select_n_i) |-> !data_oe_o)
    else $error("bus driven outside a read");
  los_set_a: assert property (cd_hi |-> ##[0:6] los_alarm_status_o)
    else $error("loss of signal not flagged");
  ref_lock_a: assert property (cd_hi |-> ##[0:6] cdr_ref_lock_o)
    else $error("recovery not on reference");
  line_track_a: assert property (cd_lo |-> ##[0:6] !cdr_ref_lock_o)
    else $error("recovery not on line");
  ref_mult_a: assert property (cdr_ref_mult_o == 4'h8)
    else $error("reference multiple wrong");
  pd_hold_a: assert property (pd_lo |-> powerdown_o && ctrl_o == 8'h00 && !irq_n_oe_o)
    else $error("reset pin not honoured");
  rst_clear_a: assert property ($fell(sys_rst_i) |-> !irq_n_oe_o && ctrl_o == 8'h00)
    else $error("state not clear after reset");
  cs_ignore_a: assert property (cs_off |=> $stable(ctrl_o))
    else $error("control changed unselected");
endmodule // hwic_chk
bind hwic_top hwic_chk u_hwic_chk (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .chip_select_n_i(chip_select_n_i),
  .read_strobe_n_i(read_strobe_n_i), .carrier_detect_in_i(carrier_detect_in_i),
  .reset_powerdown_n_i(reset_powerdown_n_i), .data_oe_o(data_oe_o), .irq_n_oe_o(irq_n_oe_o),
  .los_alarm_status_o(los_alarm_status_o), .cdr_ref_lock_o(cdr_ref_lock_o),
  .cdr_ref_mult_o(cdr_ref_mult_o), .powerdown_o(powerdown_o), .ctrl_o(ctrl_o));
`default_nettype wire

// File: test/hwic_host_model.sv
// Host model: drives the register bus pins
// Assumes calls from one process only
`default_nettype none
module hwic_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] data_o,
  input  wire logic       data_oe_o,
  output var  logic [7:0] addr_o,
  output var  logic       ale_o,
  output var  logic       cs_n_o,
  output var  logic       wr_n_o,
  output var  logic       rd_n_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus, latch open
  initial {addr_o, ale_o, cs_n_o, wr_n_o, rd_n_o, wdata_o} = {8'h00, 4'hF, 8'h00};
  // One access; strobe low seven clocks, then high six clocks before select is released
  task automatic access(input logic [7:0] a, d, input logic wr, sel, output logic [7:0] q);
    @(posedge clock_i);
    {addr_o, ale_o, cs_n_o, wdata_o} <= {a, 1'b1, !sel, d};
    @(posedge clock_i);
    {addr_o, ale_o, wr_n_o, rd_n_o} <= {~a, 1'b0, !wr, wr};
    repeat (6) @(posedge clock_i);
    #1 q = data_oe_o ? data_o : ~data_o;
    @(posedge clock_i);
    {wr_n_o, rd_n_o, wdata_o} <= {2'h3, ~d};
    repeat (6) @(posedge clock_i);
    {cs_n_o, ale_o} <= 2'h3;
  endtask
endmodule // hwic_host_model
`default_nettype wire

// File: test/test_hwic_top.sv
// Bench: write, interrupt, carrier and reset-pin scenarios
// Assumes the bound checker and the host model
`include "hwic_defines.vh"
`default_nettype none
module test_hwic_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i, sys_rst_i, addr_latch_en_i, chip_select_n_i, write_strobe_n_i, read_strobe_n_i;
  logic       data_oe_o, irq_n_o, irq_n_oe_o, los_alarm_status_o, cdr_ref_lock_o, powerdown_o;
  logic       carrier_detect_in_i, reset_powerdown_n_i, factory_test_clk_i;
  logic [7:0] addr_i, data_i, data_o, alarm_src_i, ctrl_o, dq;
  logic [3:0] cdr_ref_mult_o;
  int         mismatches, n_checks;
  wire logic  irq = irq_n_oe_o ? irq_n_o : 1'b1; // Pull-up when released
  hwic_top u_hwic_top (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .addr_latch_en_i(addr_latch_en_i),
    .chip_select_n_i(chip_select_n_i), .write_strobe_n_i(write_strobe_n_i), .read_strobe_n_i(read_strobe_n_i),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o),
    .carrier_detect_in_i(carrier_detect_in_i), .reset_powerdown_n_i(reset_powerdown_n_i),
    .factory_test_clk_i(factory_test_clk_i), .alarm_src_i(alarm_src_i), .los_alarm_status_o(los_alarm_status_o),
    .cdr_ref_lock_o(cdr_ref_lock_o), .cdr_ref_mult_o(cdr_ref_mult_o), .powerdown_o(powerdown_o), .ctrl_o(ctrl_o));
  hwic_host_model u_host (.clock_i, .data_o, .data_oe_o, .addr_o(addr_i), .ale_o(addr_latch_en_i),
    .cs_n_o(chip_select_n_i), .wr_n_o(write_strobe_n_i), .rd_n_o(read_strobe_n_i), .wdata_o(data_i));
  // Compare and count
  task automatic check(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Writes with and without select, unmapped read
  task automatic t_write();
    u_host.access(`HWIC_ADDR_CTRL, 8'hA5, 1'b1, 1'b1, dq);
    check(ctrl_o, 8'hA5);
    u_host.access(`HWIC_ADDR_CTRL, 8'h00, 1'b0, 1'b1, dq);
    check(dq, 8'hA5);
    u_host.access(`HWIC_ADDR_CTRL, 8'h3C, 1'b1, 1'b0, dq);
    check(ctrl_o, 8'hA5);
    u_host.access(8'h40, 8'h00, 1'b0, 1'b1, dq);
    check(dq, 8'h00);
  endtask
  // Masked source stays quiet; each of the first six sources raises and read releases
  task automatic t_irq();
    alarm_src_i <= 8'h08;
    repeat (8) @(posedge clock_i);
    alarm_src_i <= 8'h00;
    check({7'h00, irq}, 8'h01);
    u_host.access(`HWIC_ADDR_STATUS, 8'h00, 1'b0, 1'b1, dq);
    check(dq, 8'h01 << `HWIC_SRC_LOF);
    u_host.access(`HWIC_ADDR_MASK, 8'h00, 1'b1, 1'b1, dq);
    u_host.access(`HWIC_ADDR_MASK, 8'hFF, 1'b0, 1'b1, dq);
    check(dq, 8'h00);
    for (int i = 0; i < 6; i++) begin
      alarm_src_i <= 8'h01 << i;
      repeat (8) @(posedge clock_i);
      check({7'h00, irq}, 8'h00);
      alarm_src_i <= 8'h00;
      u_host.access(`HWIC_ADDR_STATUS, 8'h00, 1'b0, 1'b1, dq);
      check(dq, 8'h01 << i);
      check({7'h00, irq}, 8'h01);
    end
  endtask
  // Carrier high flags loss of signal and moves recovery
  task automatic t_carrier();
    carrier_detect_in_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    check({5'h00, irq, los_alarm_status_o, cdr_ref_lock_o}, 8'h03);
    check({4'h0, cdr_ref_mult_o}, {4'h0, `HWIC_REF_MULT});
    u_host.access(`HWIC_ADDR_LIVE, 8'h00, 1'b0, 1'b1, dq);
    check(dq, 8'h01 << `HWIC_SRC_LOS);
    carrier_detect_in_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    check({7'h00, cdr_ref_lock_o}, 8'h00);
  endtask
  // Reset pin clears registers and holds power-down
  task automatic t_powerdown();
    u_host.access(`HWIC_ADDR_CTRL, 8'h5A, 1'b1, 1'b1, dq);
    check(ctrl_o, 8'h5A);
    reset_powerdown_n_i <= 1'b0;
    repeat (12) @(posedge clock_i);
    check({ctrl_o[6:0], powerdown_o}, 8'h01);
    reset_powerdown_n_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    check({7'h00, powerdown_o}, 8'h00);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Watchdog well past the scenario run
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {sys_rst_i, reset_powerdown_n_i, carrier_detect_in_i, factory_test_clk_i} = 4'hC;
    alarm_src_i = 8'h00;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    check({ctrl_o[6:0], irq}, 8'h01);
    t_write();
    t_irq();
    t_carrier();
    t_powerdown();
    tally_and_finish();
  end
endmodule // test_hwic_top
`default_nettype wire
